// File: hdl/gpo_pin_defs.vh
// gpo_pin_defs.vh: offsets, field positions, reset values and code
// points of the pin 5 output control register.
// assumes it is included by bare name into modules that need the map.
`ifndef GPO_PIN_DEFS_VH
`define GPO_PIN_DEFS_VH

// register address in the 8-bit device register space
`define GPO_CTL_ADDR 8'h15
// reset value of the whole control register
`define GPO_CTL_RESET 8'h00
// read data returned for any other address
`define GPO_RD_UNMAPPED 8'h00

// field positions inside pin5_output_control
`define GPO_SEL_HI 7
`define GPO_SEL_LO 5
`define GPO_SRC_HI 4
`define GPO_SRC_LO 2
`define GPO_VAL_BIT 1
`define GPO_EN_BIT 0

// source group codes (codes 0 to 3 are the receive ports)
`define GPO_SRC_RX3 3'h3
`define GPO_SRC_DEV 3'h4
`define GPO_SRC_RSV 3'h5
`define GPO_SRC_TX0 3'h6
`define GPO_SRC_TX1 3'h7

// signal codes when a receive port is the source
`define GPO_RSEL_GPIO3 3'h3
`define GPO_RSEL_LOCK 3'h4
`define GPO_RSEL_PASS 3'h5
`define GPO_RSEL_FV 3'h6
`define GPO_RSEL_LV 3'h7

// signal codes when device status is the source
`define GPO_DSEL_VAL 3'h0
`define GPO_DSEL_LOCK_OR 3'h1
`define GPO_DSEL_PASS_AND 3'h2
`define GPO_DSEL_PASS_AND2 3'h3
`define GPO_DSEL_SYNC 3'h4

// signal codes when a transmit port is the source
`define GPO_TSEL_PASS_AND 3'h0
`define GPO_TSEL_PASS_OR 3'h1
`define GPO_TSEL_FV 3'h2
`define GPO_TSEL_LV 3'h3
`define GPO_TSEL_SYNCED 3'h4
`define GPO_TSEL_IRQ 3'h5

`endif

// File: hdl/gpo_pin_mux.v
// gpo_pin_mux: output multiplexer and driver control for pin 5.
// assumes all status inputs are synchronous to clock, and that the
// register port is driven by the device's own register access logic.
//
// Summary of operation
// - source field bits 4:2 picks group
// - rx select 000-011 gives remote values
// - rx select 100-111 gives lock/pass/fv/lv
// - status select 000 gives software level
// - status select 001 ORs enabled locks
// - status select 010/011 ANDs enabled passes
// - status select 100 gives camera sync
// - tx select 000/001 AND/OR selected status
// - tx select 010/011 frame/line valid
// - tx select 100 synced, 101 interrupt
// - bit 1 holds the software level
// - bit 0 enables the pin driver
`timescale 1ns/1ps
`default_nettype none
`include "gpo_pin_defs.vh"

module gpo_pin_mux (
    // device clock, 20 MHz
    input wire clock,
    // synchronous reset, active low
    input wire nrst,
    // freezes every flip-flop while low and nrst is high
    input wire clk_en,
    // register access port, 8-bit address space
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // per receive port: four forwarded values each, port 0 lowest
    input wire [15:0] rx_remote_gpio,
    input wire [3:0] rx_lock,
    input wire [3:0] rx_pass,
    input wire [3:0] rx_frame_valid,
    input wire [3:0] rx_line_valid,
    // receive ports that are enabled in the device
    input wire [3:0] rx_port_enabled,
    // internal frame synchronisation signal
    input wire camera_sync_signal,
    // receive ports mapped to each transmit port, tx0 in [3:0]
    input wire [7:0] tx_rx_select,
    // per transmit port status
    input wire [1:0] tx_frame_valid,
    input wire [1:0] tx_line_valid,
    input wire [1:0] tx_synced,
    input wire [1:0] tx_interrupt,
    // pin level and active-low driver enable
    output reg pin5_out_q,
    output reg pin5_drive_n_q
);

    ////////////////////////////////////////////////////////////////////
    // reduction helpers, each used for both status and transmit groups

    // AND over the masked ports; an empty mask yields 0 so that a pin
    // never claims "all passing" when nothing is being watched
    function mask_and;
        input [3:0] mask;
        input [3:0] val;
        begin
            mask_and = (|mask) & (&(val | ~mask));
        end
    endfunction

    // OR over the masked ports; an empty mask naturally yields 0
    function mask_or;
        input [3:0] mask;
        input [3:0] val;
        begin
            mask_or = |(val & mask);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // control register

    // pin5_output_control storage
    reg [7:0] ctl_q;
    // next value of the control register
    reg [7:0] ctl_d;
    // write strobe decoded for this register
    wire ctl_hit_wr;
    // read strobe decoded for this register
    wire ctl_hit_rd;

    assign ctl_hit_wr = reg_wr & (reg_addr == `GPO_CTL_ADDR);
    assign ctl_hit_rd = reg_rd & (reg_addr == `GPO_CTL_ADDR);

    // all eight bits are plain read/write storage
    always @* begin
        ctl_d = ctl_q;
        if (ctl_hit_wr) begin
            ctl_d = reg_wdata;
        end
    end

    // register update, frozen by the clock enable
    always @(posedge clock) begin
        if (!nrst) begin
            ctl_q <= `GPO_CTL_RESET;
        end else if (clk_en) begin
            ctl_q <= ctl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    // read data; unmapped addresses read as zero, and the data stays
    // until the next read so a slow reader can sample it late
    reg [7:0] rdata_d;

    always @* begin
        rdata_d = reg_rdata_q;
        if (ctl_hit_rd) begin
            rdata_d = ctl_q;
        end else if (reg_rd) begin
            rdata_d = `GPO_RD_UNMAPPED;
        end
    end

    // registered read data
    always @(posedge clock) begin
        if (!nrst) begin
            reg_rdata_q <= `GPO_CTL_RESET;
        end else if (clk_en) begin
            reg_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field extraction

    // pin5_signal_select
    wire [2:0] pin5_signal_select;
    // pin5_source_group
    wire [2:0] pin5_source_group;
    // pin5_software_level
    wire pin5_software_level;
    // pin5_drive_enable
    wire pin5_drive_enable;

    assign pin5_signal_select = ctl_q[`GPO_SEL_HI:`GPO_SEL_LO];
    assign pin5_source_group = ctl_q[`GPO_SRC_HI:`GPO_SRC_LO];
    assign pin5_software_level = ctl_q[`GPO_VAL_BIT];
    assign pin5_drive_enable = ctl_q[`GPO_EN_BIT];

    ////////////////////////////////////////////////////////////////////
    // receive port groups

    // chosen signal of each receive port
    wire [3:0] rx_choice;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_rx
            gpo_rx_sel u_rx_sel (
                .sel(pin5_signal_select),
                .remote_gpio(rx_remote_gpio[4*gi+3:4*gi]),
                .lock(rx_lock[gi]),
                .pass(rx_pass[gi]),
                .frame_valid(rx_frame_valid[gi]),
                .line_valid(rx_line_valid[gi]),
                .sel_out(rx_choice[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // device status group

    // chosen device status signal
    reg dev_choice;

    always @* begin
        case (pin5_signal_select)
            `GPO_DSEL_VAL: begin
                dev_choice = pin5_software_level;
            end
            `GPO_DSEL_LOCK_OR: begin
                dev_choice = mask_or(rx_port_enabled, rx_lock);
            end
            `GPO_DSEL_PASS_AND, `GPO_DSEL_PASS_AND2: begin
                dev_choice = mask_and(rx_port_enabled, rx_pass);
            end
            `GPO_DSEL_SYNC: begin
                dev_choice = camera_sync_signal;
            end
            default: begin
                dev_choice = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // transmit port groups

    // chosen signal of each transmit port; each bit has one driver
    wire [1:0] tx_choice;

    genvar gt;
    generate
        for (gt = 0; gt < 2; gt = gt + 1) begin : g_tx
            // receive ports mapped onto this transmit port
            wire [3:0] mapped;
            // chosen signal of this transmit port alone
            reg choice;
            assign mapped = tx_rx_select[4*gt+3:4*gt];
            assign tx_choice[gt] = choice;

            always @* begin
                case (pin5_signal_select)
                    `GPO_TSEL_PASS_AND: begin
                        choice = mask_and(mapped, rx_pass);
                    end
                    `GPO_TSEL_PASS_OR: begin
                        choice = mask_or(mapped, rx_pass);
                    end
                    `GPO_TSEL_FV: begin
                        choice = tx_frame_valid[gt];
                    end
                    `GPO_TSEL_LV: begin
                        choice = tx_line_valid[gt];
                    end
                    `GPO_TSEL_SYNCED: begin
                        choice = tx_synced[gt];
                    end
                    `GPO_TSEL_IRQ: begin
                        choice = tx_interrupt[gt];
                    end
                    default: begin
                        choice = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // source group selection

    // level that the pin would carry when enabled
    reg pin_level;

    always @* begin
        case (pin5_source_group)
            // receive ports 0 to 3
            3'h0, 3'h1, 3'h2, `GPO_SRC_RX3: begin
                pin_level = rx_choice[pin5_source_group[1:0]];
            end
            // device status
            `GPO_SRC_DEV: begin
                pin_level = dev_choice;
            end
            // transmit ports 0 and 1
            `GPO_SRC_TX0: begin
                pin_level = tx_choice[0];
            end
            `GPO_SRC_TX1: begin
                pin_level = tx_choice[1];
            end
            default: begin
                pin_level = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // pin driver flops

    // next pin level and driver enable
    reg pin_out_d;
    reg pin_drive_n_d;

    // a disabled pin is released and its level parked low, so that a
    // later enable never shows a stale value for a cycle
    always @* begin
        if (pin5_drive_enable) begin
            pin_out_d = pin_level;
            pin_drive_n_d = 1'b0;
        end else begin
            pin_out_d = 1'b0;
            pin_drive_n_d = 1'b1;
        end
    end

    // registered pin outputs; one cycle of latency is the price of
    // glitch-free pin timing across the wide multiplexer
    always @(posedge clock) begin
        if (!nrst) begin
            pin5_out_q <= 1'b0;
            pin5_drive_n_q <= 1'b1;
        end else if (clk_en) begin
            pin5_out_q <= pin_out_d;
            pin5_drive_n_q <= pin_drive_n_d;
        end
    end

endmodule

`default_nettype wire

// File: hdl/gpo_rx_sel.v
// gpo_rx_sel: picks one signal out of a single receive port's group.
// assumes the select code is stable from a register and inputs are
// synchronous to the device clock; the result is registered downstream.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_pin_defs.vh"

module gpo_rx_sel (
    input wire [2:0] sel,
    input wire [3:0] remote_gpio,
    input wire lock,
    input wire pass,
    input wire frame_valid,
    input wire line_valid,
    output reg sel_out
);

    ////////////////////////////////////////////////////////////////////
    // signal choice within one receive port
    always @* begin
        case (sel)
            3'h0, 3'h1, 3'h2, `GPO_RSEL_GPIO3: begin
                sel_out = remote_gpio[sel[1:0]];
            end
            `GPO_RSEL_LOCK: begin
                sel_out = lock;
            end
            `GPO_RSEL_PASS: begin
                sel_out = pass;
            end
            `GPO_RSEL_FV: begin
                sel_out = frame_valid;
            end
            `GPO_RSEL_LV: begin
                sel_out = line_valid;
            end
            // every code is listed; kept for safety
            default: begin
                sel_out = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// File: verification/gpo_board.sv
// gpo_board: board logic on pin 5, resolving the wire level.
// assumes no pull resistor, so a released pin holds no valid level.
`timescale 1ns/1ps
`default_nettype none
module gpo_board (
    input wire logic clock,
    input wire logic pin5_out_q,
    input wire logic pin5_drive_n_q,
    output logic pin_level
);
    // last driven level; a floating line shows its inverse, never a copy
    logic last_q = 1'b0;
    always @(posedge clock) begin
        if (!pin5_drive_n_q)
            last_q <= pin5_out_q;
    end
    assign pin_level = pin5_drive_n_q ? ~last_q : pin5_out_q;
endmodule
`default_nettype wire

// File: verification/gpo_pin_chk.sv
// gpo_pin_chk: timing and mux assertions on the gpo_pin_mux ports.
// assumes one clock domain and a control register only at its address.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_pin_defs.vh"
module gpo_pin_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [15:0] rx_remote_gpio,
    input wire logic [3:0] rx_lock,
    input wire logic [3:0] rx_pass,
    input wire logic [3:0] rx_port_enabled,
    input wire logic camera_sync_signal,
    input wire logic pin5_out_q,
    input wire logic pin5_drive_n_q
);
    // shadow of the control register; reset wins even while frozen
    logic [7:0] ctl_q;
    logic [2:0] src, sel;
    logic go, on;
    // expected levels, named so that $past only ever sees plain signals
    logic lock_or, pass_and, rx_val, rx_lk;
    logic [7:0] rd_exp;
    assign src = ctl_q[4:2];
    assign sel = ctl_q[7:5];
    assign go = clk_en && nrst;
    assign on = go && ctl_q[0];
    assign lock_or = |(rx_lock & rx_port_enabled);
    assign pass_and = |rx_port_enabled && &(rx_pass | ~rx_port_enabled);
    assign rx_val = rx_remote_gpio[{src[1:0], sel[1:0]}];
    assign rx_lk = rx_lock[src[1:0]];
    assign rd_exp = (reg_addr == `GPO_CTL_ADDR) ? ctl_q : `GPO_RD_UNMAPPED;
    always @(posedge clock) begin
        if (!nrst)
            ctl_q <= `GPO_CTL_RESET;
        else if (go && reg_wr && reg_addr == `GPO_CTL_ADDR)
            ctl_q <= reg_wdata;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_drive_enable: assert property (go |=> pin5_drive_n_q == !$past(ctl_q[0]))
        else $error("driver enable does not follow bit 0");
    a_off_low: assert property (pin5_drive_n_q |-> !pin5_out_q)
        else $error("pin level high while released");
    a_sw_level: assert property (on && src == 4 && sel == 0
        |=> pin5_out_q == $past(ctl_q[1]))
        else $error("software level not on pin");
    a_lock_or: assert property (on && src == 4 && sel == 1
        |=> pin5_out_q == $past(lock_or))
        else $error("lock or wrong");
    a_pass_and: assert property (on && src == 4 && sel[2:1] == 1
        |=> pin5_out_q == $past(pass_and))
        else $error("pass and wrong");
    a_sync_out: assert property (on && src == 4 && sel == 4
        |=> pin5_out_q == $past(camera_sync_signal))
        else $error("sync signal not on pin");
    a_rx_value: assert property (on && !src[2] && !sel[2]
        |=> pin5_out_q == $past(rx_val))
        else $error("forwarded value wrong");
    a_rx_lock: assert property (on && !src[2] && sel == 4
        |=> pin5_out_q == $past(rx_lk))
        else $error("port lock wrong");
    a_resv_low: assert property (on && (src == 5 || src == 4 && sel > 4) |=> !pin5_out_q)
        else $error("reserved code drives high");
    a_read_back: assert property (go && reg_rd |=> reg_rdata_q == $past(rd_exp))
        else $error("read data wrong");
    a_outputs_frozen: assert property (!clk_en
        |=> $stable({pin5_out_q, pin5_drive_n_q, reg_rdata_q}))
        else $error("outputs moved while frozen");
    c_tx_irq: cover property (on && src == 6 && sel == 5 ##1 pin5_out_q);
    c_resv: cover property (on && src == 5);
    c_unmapped: cover property (go && reg_rd && reg_addr != `GPO_CTL_ADDR);
endmodule
bind gpo_pin_mux gpo_pin_chk u_gpo_pin_chk (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_q, .rx_remote_gpio, .rx_lock, .rx_pass, .rx_port_enabled,
    .camera_sync_signal, .pin5_out_q, .pin5_drive_n_q);
`default_nettype wire

// File: verification/test_gpo_pin_mux.sv
// test_gpo_pin_mux: register access and full mux sweep of pin 5.
// assumes a 20 MHz clock and the board model on the pin.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_pin_defs.vh"
module test_gpo_pin_mux;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] rx_remote_gpio = 16'h0000;
    logic [3:0] rx_lock = 4'h0, rx_pass = 4'h0, rx_frame_valid = 4'h0;
    logic [3:0] rx_line_valid = 4'h0, rx_port_enabled = 4'h0;
    logic camera_sync_signal = 1'b0;
    logic [7:0] tx_rx_select = 8'h00;
    logic [1:0] tx_frame_valid = 2'h0, tx_line_valid = 2'h0;
    logic [1:0] tx_synced = 2'h0, tx_interrupt = 2'h0;
    logic [7:0] reg_rdata_q;
    logic pin5_out_q, pin5_drive_n_q, pin_level;
    int error_cnt = 0, num_checks = 0;
    // input patterns: enabled masks 0011, 1101 and empty
    logic [52:0] pats [3] = '{53'h0a_5c3f_e0e6_5a96, 53'h1f_f0c3_bffb_3c42,
        53'h15_c3ae_4681_a596};
    always #25 clock = ~clock;
    gpo_pin_mux u_gpo_pin_mux (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .rx_remote_gpio, .rx_lock, .rx_pass, .rx_frame_valid,
        .rx_line_valid, .rx_port_enabled, .camera_sync_signal, .tx_rx_select,
        .tx_frame_valid, .tx_line_valid, .tx_synced, .tx_interrupt, .pin5_out_q,
        .pin5_drive_n_q);
    gpo_board u_gpo_board (.clock, .pin5_out_q, .pin5_drive_n_q, .pin_level);
    ////////////////////////////////////////////////////////////////
    // expected pin level worked out from the bench's own inputs
    function automatic logic ref_out(input logic [7:0] c);
        logic [7:0] v;
        logic [3:0] m;
        logic t;
        t = c[2];
        m = tx_rx_select[{t, 2'b00} +: 4];
        case (c[4:2])
            3'h4: v = {3'h0, camera_sync_signal,
                {2{|rx_port_enabled && &(rx_pass | ~rx_port_enabled)}},
                |(rx_lock & rx_port_enabled), c[1]};
            3'h5: v = 8'h00;
            3'h6, 3'h7: v = {2'h0, tx_interrupt[t], tx_synced[t], tx_line_valid[t],
                tx_frame_valid[t], |(rx_pass & m), |m && &(rx_pass | ~m)};
            default: v = {rx_line_valid[c[3:2]], rx_frame_valid[c[3:2]], rx_pass[c[3:2]],
                rx_lock[c[3:2]], rx_remote_gpio[{c[3:2], 2'b00} +: 4]};
        endcase
        return c[0] & v[c[7:5]];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask
    // a write shows at the pin one edge after it is taken
    task automatic pin_chk(input logic [7:0] c);
        @(posedge clock);
        #1 chk({6'h00, pin5_drive_n_q, pin5_out_q}, {6'h00, ~c[0], ref_out(c)});
        if (c[0])
            chk({7'h00, pin_level}, {7'h00, ref_out(c)});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        rd(`GPO_CTL_ADDR, `GPO_CTL_RESET);
        chk({6'h00, pin5_drive_n_q, pin5_out_q}, 8'h02);
        $display("test reset done");
        wr(`GPO_CTL_ADDR, 8'ha6);
        wr(8'h16, 8'hff);
        rd(8'h14, `GPO_RD_UNMAPPED);
        rd(`GPO_CTL_ADDR, 8'ha6);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(`GPO_CTL_ADDR, 8'h00);
        @(posedge clock);
        clk_en <= 1'b1;
        rd(`GPO_CTL_ADDR, 8'ha6);
        $display("test register done");
        for (int p = 0; p < 3; p++) begin
            @(posedge clock);
            {rx_remote_gpio, rx_lock, rx_pass, rx_frame_valid, rx_line_valid,
                rx_port_enabled, camera_sync_signal, tx_rx_select, tx_frame_valid,
                tx_line_valid, tx_synced, tx_interrupt} <= pats[p];
            for (int c = 0; c < 64; c++) begin
                wr(`GPO_CTL_ADDR, {c[5:0], p[0], 1'b1});
                pin_chk({c[5:0], p[0], 1'b1});
            end
            wr(`GPO_CTL_ADDR, 8'h12);
            pin_chk(8'h12);
        end
        $display("test sweep done");
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(`GPO_CTL_ADDR, `GPO_CTL_RESET);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
